// ### verilog/pfc_host.sv
// Host-side controller that drives a parallel NOR flash through its strobes
// What this block does
// - Read: chip and output enable low, write enable high.
// - Command write: write and chip enable low, output enable high.
// - Host pulses o_retry when a reset interrupted an embedded algorithm.
// - Group protect: high level on A9 and output enable, A6 low, pulse write enable.
// - Chip unprotect: high level on output enable and A9, A6 high, pulse write enable.
// - Host should protect every group before chip unprotect; this block issues chip unprotect without protecting any group first.
// - Protect and unprotect may use only the reset high level with bus timing.
`include "pfc_params.svh"
module pfc_host (
  input  wire logic                     i_clk,
  input  wire logic                     i_reset,
  input  wire pfc_pkg::pfc_req_t        i_req,
  input  wire logic                     i_req_valid,
  input  wire logic                     i_alt_method,
  input  wire logic                     i_wp_n,
  output logic                          o_req_ready,
  output logic [`PFC_DATA_W-1:0]        o_rd_data,
  output logic                          o_rd_valid,
  output logic                          o_retry,
  output pfc_pkg::pfc_strobe_t          o_strobe,
  output logic [`PFC_ADDR_W-1:0]        o_addr,
  output logic [`PFC_DATA_W-1:0]        o_dq_out,
  output logic                          o_dq_oe,
  output logic                          o_wp_n,
  input  wire logic [`PFC_DATA_W-1:0]   i_dq_in,
  input  wire logic                     i_ready_busy_n
);
  typedef enum logic [2:0] {
    PFC_ST_IDLE,
    PFC_ST_SETUP,
    PFC_ST_STROBE,
    PFC_ST_RECOVER,
    PFC_ST_RST_LOW,
    PFC_ST_RST_WAIT
  } pfc_state_t;

  pfc_state_t                  state_q;
  pfc_pkg::pfc_req_t           req_q;
  logic [`PFC_CNT_W-1:0]       cnt_q;
  logic                        busy_at_reset_q;
  logic                        rb_sync;
  logic [`PFC_DATA_W-1:0]      dq_sync;
  pfc_pkg::pfc_strobe_t        act_strobe;

  // Every device pin input passes the three-stage synchroniser
  pfc_sync u_rb_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (i_ready_busy_n),
    .o_level (rb_sync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `PFC_DATA_W; gi++) begin : g_dq_sync
      pfc_sync u_dq_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async (i_dq_in[gi]),
        .o_level (dq_sync[gi])
      );
    end
  endgenerate

  // Strobe pattern for the active phase of each operation
  function automatic pfc_pkg::pfc_strobe_t active_strobe(input pfc_pkg::pfc_op_t op, input logic alt);
    pfc_pkg::pfc_strobe_t s;
    s = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1, a9_hv: 1'b0, oe_hv: 1'b0, reset_hv: 1'b0};
    case (op)
      pfc_pkg::PFC_OP_READ: begin
        s.oe_n = 1'b0;
      end
      pfc_pkg::PFC_OP_WRITE: begin
        s.we_n = 1'b0;
      end
      pfc_pkg::PFC_OP_PROTECT, pfc_pkg::PFC_OP_UNPROTECT: begin
        s.we_n = 1'b0;
        if (alt) begin
          s.reset_hv = 1'b1;
        end else begin
          s.a9_hv = 1'b1;
          s.oe_hv = 1'b1;
        end
      end
      pfc_pkg::PFC_OP_VERIFY: begin
        s.oe_n  = 1'b0;
        s.a9_hv = 1'b1;
      end
      default: begin
        s.ce_n = 1'b1;
      end
    endcase
    return s;
  endfunction : active_strobe

  function automatic pfc_pkg::pfc_strobe_t idle_strobe();
    return '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1, a9_hv: 1'b0, oe_hv: 1'b0, reset_hv: 1'b0};
  endfunction : idle_strobe

  always_comb begin
    act_strobe = active_strobe(req_q.op, i_alt_method);
  end

  // Sequencer
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= PFC_ST_IDLE;
      cnt_q   <= '0;
      req_q   <= '0;
    end else begin
      case (state_q)
        PFC_ST_IDLE: begin
          if (i_req_valid) begin
            req_q <= i_req;
            cnt_q <= '0;
            state_q <= (i_req.op == pfc_pkg::PFC_OP_RESET) ? PFC_ST_RST_LOW : PFC_ST_SETUP;
          end
        end
        PFC_ST_SETUP: begin
          cnt_q   <= '0;
          state_q <= PFC_ST_STROBE;
        end
        PFC_ST_STROBE: begin
          // Reads wait address access time plus the synchroniser depth
          if (req_q.op == pfc_pkg::PFC_OP_READ || req_q.op == pfc_pkg::PFC_OP_VERIFY) begin
            if (cnt_q == `PFC_CNT_W'(`PFC_CYC_ACC + 3)) begin
              state_q <= PFC_ST_RECOVER;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end else if (cnt_q == `PFC_CNT_W'(`PFC_CYC_WP)) begin
            state_q <= PFC_ST_RECOVER;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        PFC_ST_RECOVER: begin
          state_q <= PFC_ST_IDLE;
        end
        PFC_ST_RST_LOW: begin
          if (cnt_q == `PFC_CNT_W'(`PFC_CYC_RP)) begin
            cnt_q   <= '0;
            state_q <= PFC_ST_RST_WAIT;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        PFC_ST_RST_WAIT: begin
          // Busy at reset: wait for ready; else wait reset-to-read time
          if (busy_at_reset_q) begin
            if (rb_sync || cnt_q == `PFC_CNT_W'(`PFC_CYC_READY)) begin
              state_q <= PFC_ST_IDLE;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end else if (cnt_q == `PFC_CNT_W'(`PFC_CYC_RH)) begin
            state_q <= PFC_ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= PFC_ST_IDLE;
        end
      endcase
    end
  end

  // Remember whether an embedded algorithm was cut by the reset
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      busy_at_reset_q <= 1'b0;
      o_retry         <= 1'b0;
    end else begin
      o_retry <= 1'b0;
      // Sampled at the end of the pulse, after ready_busy_n has crossed the synchroniser
      if (state_q == PFC_ST_RST_LOW && cnt_q == `PFC_CNT_W'(`PFC_CYC_RP)) begin
        busy_at_reset_q <= ~rb_sync;
      end
      if (state_q == PFC_ST_RST_WAIT && busy_at_reset_q && (rb_sync || cnt_q == `PFC_CNT_W'(`PFC_CYC_READY))) begin
        o_retry <= 1'b1;
      end
    end
  end

  // Pin drive
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_strobe <= idle_strobe();
      o_addr   <= '0;
      o_dq_out <= `PFC_WORD_ZERO;
      o_dq_oe  <= 1'b0;
    end else begin
      case (state_q)
        PFC_ST_SETUP, PFC_ST_STROBE, PFC_ST_RECOVER: begin
          // Chip enable and qualifiers frame the strobe on both sides
          o_strobe <= act_strobe;
          if (state_q != PFC_ST_STROBE) begin
            o_strobe.oe_n <= 1'b1;
            o_strobe.we_n <= 1'b1;
          end
          o_addr <= req_q.addr;
          if (req_q.op == pfc_pkg::PFC_OP_PROTECT) begin
            o_addr[`PFC_A6_BIT] <= 1'b0;
            o_addr[`PFC_A1_BIT] <= 1'b1;
          end else if (req_q.op == pfc_pkg::PFC_OP_UNPROTECT) begin
            o_addr[`PFC_A6_BIT] <= 1'b1;
            o_addr[`PFC_A1_BIT] <= 1'b1;
          end else if (req_q.op == pfc_pkg::PFC_OP_VERIFY) begin
            o_addr[`PFC_A6_BIT] <= 1'b0;
            o_addr[`PFC_A1_BIT] <= 1'b1;
          end
          o_dq_out <= req_q.data;
          o_dq_oe  <= (req_q.op == pfc_pkg::PFC_OP_WRITE);
        end
        PFC_ST_RST_LOW: begin
          o_strobe         <= idle_strobe();
          o_strobe.reset_n <= 1'b0;
          o_dq_oe          <= 1'b0;
        end
        default: begin
          o_strobe <= idle_strobe();
          o_dq_oe  <= 1'b0;
        end
      endcase
    end
  end

  // Read capture and handshake
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rd_data   <= `PFC_WORD_ZERO;
      o_rd_valid  <= 1'b0;
      o_req_ready <= 1'b0;
      o_wp_n      <= 1'b0;
    end else begin
      o_wp_n      <= i_wp_n;
      o_rd_valid  <= 1'b0;
      o_req_ready <= (state_q == PFC_ST_IDLE) && !i_req_valid;
      if (state_q == PFC_ST_STROBE && cnt_q == `PFC_CNT_W'(`PFC_CYC_ACC + 3)
          && (req_q.op == pfc_pkg::PFC_OP_READ || req_q.op == pfc_pkg::PFC_OP_VERIFY)) begin
        o_rd_data  <= dq_sync;
        if (req_q.op == pfc_pkg::PFC_OP_VERIFY) begin
          o_rd_data <= {{(`PFC_DATA_W-1){1'b0}}, dq_sync[`PFC_Q0_BIT]};
        end
        o_rd_valid <= 1'b1;
      end
    end
  end
endmodule : pfc_host

// ### verilog/pfc_params.svh
// Timing and field constants for the parallel flash host controller
`ifndef PFC_PARAMS_SVH
`define PFC_PARAMS_SVH
`define PFC_CLK_PERIOD_NS      8
`define PFC_T_ACC_NS           90
`define PFC_T_RP_NS            500
`define PFC_T_RH_NS            50
`define PFC_T_READY_NS         20000
`define PFC_T_WP_NS            35
`define PFC_T_SLEEP_MARGIN_NS  30
`define PFC_CYC_UP(ns)         (((ns) + `PFC_CLK_PERIOD_NS - 1) / `PFC_CLK_PERIOD_NS)
`define PFC_CYC_ACC            `PFC_CYC_UP(`PFC_T_ACC_NS)
`define PFC_CYC_RP             `PFC_CYC_UP(`PFC_T_RP_NS)
`define PFC_CYC_RH             `PFC_CYC_UP(`PFC_T_RH_NS)
`define PFC_CYC_WP             `PFC_CYC_UP(`PFC_T_WP_NS)
`define PFC_CYC_READY          (`PFC_T_READY_NS / `PFC_CLK_PERIOD_NS)
`define PFC_CNT_W              12
`define PFC_ADDR_W             22
`define PFC_DATA_W             16
`define PFC_A1_BIT             1
`define PFC_A6_BIT             6
`define PFC_A9_BIT             9
`define PFC_Q0_BIT             0
`define PFC_WORD_ZERO          16'h0000
`endif

// ### verilog/pfc_pkg.sv
// Types shared by the parallel flash host controller
package pfc_pkg;
  typedef enum logic [2:0] {
    PFC_OP_READ,
    PFC_OP_WRITE,
    PFC_OP_PROTECT,
    PFC_OP_UNPROTECT,
    PFC_OP_VERIFY,
    PFC_OP_RESET
  } pfc_op_t;

  typedef struct packed {
    pfc_op_t     op;
    logic [21:0] addr;
    logic [15:0] data;
  } pfc_req_t;

  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        reset_n;
    logic        a9_hv;
    logic        oe_hv;
    logic        reset_hv;
  } pfc_strobe_t;
endpackage : pfc_pkg

// ### verilog/pfc_sync.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree
module pfc_sync (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_async,
  output logic      o_level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_level <= 1'b1;
    end else if (s2_q == s3_q) begin
      o_level <= s3_q;
    end
  end
endmodule : pfc_sync

// ### bench/pfc_host_sva.sv
// Pin-level checks bound to the parallel flash host controller
`include "pfc_params.svh"
module pfc_host_sva (
  input  wire logic                 i_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_wp_n,
  input  wire logic                 o_rd_valid,
  input  wire logic                 o_dq_oe,
  input  wire logic                 o_wp_n,
  input  wire pfc_pkg::pfc_strobe_t o_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] low_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Length of the current reset pulse in cycles
  always_ff @(posedge i_clk) begin
    if (i_reset || o_strobe.reset_n) begin
      low_q <= 12'h000;
    end else begin
      low_q <= low_q + 12'h001;
    end
  end
  sequence oe_drop_s;
    $fell(o_strobe.oe_n);
  endsequence
  sequence oe_hold_s;
    (!o_strobe.oe_n && !o_rd_valid)[*8];
  endsequence
  read_we_a: assert property (!o_strobe.ce_n && !o_strobe.oe_n |-> o_strobe.we_n)
    else $error("read strobes with write enable low");
  write_oe_a: assert property (!o_strobe.we_n |-> !o_strobe.ce_n && o_strobe.oe_n)
    else $error("write pulse without chip enable or with output enable");
  bus_turn_a: assert property (o_dq_oe |-> o_strobe.oe_n)
    else $error("host drives data while output enable low");
  reset_idle_a: assert property ($fell(i_reset) |-> o_strobe == 7'h78 && !o_dq_oe)
    else $error("strobes not idle after reset");
  read_latency_a: assert property (oe_drop_s |-> oe_hold_s ##[1:40] o_rd_valid)
    else $error("read word early or missing");
  rd_pulse_a: assert property (o_rd_valid |=> !o_rd_valid)
    else $error("read valid longer than one cycle");
  rst_pulse_a: assert property ($rose(o_strobe.reset_n) |-> low_q >= 12'(`PFC_CYC_RP))
    else $error("reset pulse too short");
  hv_pair_a: assert property (!o_strobe.we_n && o_strobe.a9_hv |-> o_strobe.oe_hv && !o_strobe.reset_hv)
    else $error("protect pulse without both qualifiers");
  alt_only_a: assert property (o_strobe.reset_hv |-> !o_strobe.a9_hv && !o_strobe.oe_hv)
    else $error("reset qualifier mixed with pin qualifiers");
  wp_copy_a: assert property ($stable(i_wp_n)[*6] |-> o_wp_n == i_wp_n)
    else $error("write protect pin does not follow request");
endmodule : pfc_host_sva

// ### bench/pfc_flash_model.sv
// Behavioural parallel flash device answering the host controller
module pfc_flash_model #(
  parameter logic [15:0] ID_CODE  = 16'h0F3D, // Arbitrary identification value
  parameter int          BUSY_CYC = 200
) (
  input  wire logic                 i_clk,
  input  wire pfc_pkg::pfc_strobe_t i_strobe,
  input  wire logic [21:0]          i_addr,
  input  wire logic                 i_wp_n,
  output logic [15:0]               o_dq = 16'h0000,
  output logic                      o_ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] prot_q = 32'h0; // Shipped unprotected
  logic [11:0] busy_q = 12'h000;
  logic        we_q   = 1'b1;
  logic        rise;
  logic        locked;
  assign rise   = i_strobe.we_n && !we_q && !i_strobe.ce_n && i_strobe.reset_n;
  assign locked = prot_q[i_addr[21:17]] || (!i_wp_n && i_addr[21:15] == 7'h00);
  assign o_ready_busy_n = (busy_q == 12'h000);
  always_ff @(posedge i_clk) begin
    we_q <= i_strobe.we_n;
  end
  // Protection changes on the rising edge of write enable
  always_ff @(posedge i_clk) begin
    if (rise && (i_strobe.reset_hv || (i_strobe.a9_hv && i_strobe.oe_hv))) begin
      if (i_addr[6]) begin
        prot_q <= 32'h0;
      end else begin
        prot_q[i_addr[21:17]] <= 1'b1;
      end
    end
  end
  // Embedded algorithm runs on through reset and chip disable
  always_ff @(posedge i_clk) begin
    if (busy_q != 12'h000) begin
      busy_q <= busy_q - 12'h001;
    end else if (rise && !i_strobe.a9_hv && !i_strobe.oe_hv && !i_strobe.reset_hv && !locked) begin
      busy_q <= 12'(BUSY_CYC);
    end
  end
  // Released bus toggles so a stale word never passes as data
  always_ff @(posedge i_clk) begin
    if (!i_strobe.reset_n || i_strobe.ce_n || i_strobe.oe_n) begin
      o_dq <= ~o_dq;
    end else if (i_strobe.a9_hv) begin
      o_dq <= i_addr[1] ? {15'h0000, prot_q[i_addr[21:17]]} : ID_CODE;
    end else begin
      o_dq <= i_addr[15:0] ^ 16'hC3A5;
    end
  end
endmodule : pfc_flash_model

// ### bench/tb_pfc_host.sv
// Self-checking bench for the parallel flash host controller
module tb_pfc_host;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    pfc_pkg::pfc_op_t op;
    logic [1:0]       mode;
    logic [21:0]      addr;
    logic [15:0]      rd;
    logic             retry;
  } pfc_row_t;
  localparam logic [15:0] NO_RD = 16'hDEAD;
  logic                 i_clk     = 1'b0;
  logic                 i_reset   = 1'b1;
  pfc_pkg::pfc_req_t    req       = '0;
  logic                 req_valid = 1'b0;
  logic [1:0]           mode      = 2'h1;
  logic                 req_ready, rd_valid, retry, dq_oe, wp_pin, rdy_n, got_retry;
  logic [15:0]          rd_data, dq, got_rd, dq_out, got_wd;
  logic [21:0]          addr;
  pfc_pkg::pfc_strobe_t strobe;
  int                   err_count = 0;
  int                   n_checks  = 0;
  // Mode is {alternate method, write protect pin}
  pfc_row_t rows [17] = '{
    '{pfc_pkg::PFC_OP_READ, 2'h1, 22'h000000, 16'hC3A5, 1'h0},
    '{pfc_pkg::PFC_OP_READ, 2'h1, 22'h3FFFFF, 16'h3C5A, 1'h0},
    '{pfc_pkg::PFC_OP_READ, 2'h1, 22'h012345, 16'hE0E0, 1'h0},
    '{pfc_pkg::PFC_OP_PROTECT, 2'h1, 22'h060000, NO_RD, 1'h0},
    '{pfc_pkg::PFC_OP_VERIFY, 2'h1, 22'h060002, 16'h0001, 1'h0},
    '{pfc_pkg::PFC_OP_VERIFY, 2'h1, 22'h080002, 16'h0000, 1'h0},
    '{pfc_pkg::PFC_OP_VERIFY, 2'h1, 22'h060000, 16'h0001, 1'h0},
    '{pfc_pkg::PFC_OP_WRITE, 2'h1, 22'h060010, NO_RD, 1'h0},
    '{pfc_pkg::PFC_OP_RESET, 2'h1, 22'h000000, NO_RD, 1'h0},
    '{pfc_pkg::PFC_OP_WRITE, 2'h1, 22'h080010, NO_RD, 1'h0},
    '{pfc_pkg::PFC_OP_RESET, 2'h1, 22'h000000, NO_RD, 1'h1},
    '{pfc_pkg::PFC_OP_WRITE, 2'h0, 22'h000010, NO_RD, 1'h0},
    '{pfc_pkg::PFC_OP_RESET, 2'h0, 22'h000000, NO_RD, 1'h0},
    '{pfc_pkg::PFC_OP_UNPROTECT, 2'h3, 22'h000040, NO_RD, 1'h0},
    '{pfc_pkg::PFC_OP_VERIFY, 2'h1, 22'h060002, 16'h0000, 1'h0},
    '{pfc_pkg::PFC_OP_PROTECT, 2'h3, 22'h0A0000, NO_RD, 1'h0},
    '{pfc_pkg::PFC_OP_VERIFY, 2'h1, 22'h0A0002, 16'h0001, 1'h0}
  };
  pfc_host dut (
    .i_clk, .i_reset, .i_req(req), .i_req_valid(req_valid), .i_alt_method(mode[1]), .i_wp_n(mode[0]),
    .o_req_ready(req_ready), .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_retry(retry), .o_strobe(strobe),
    .o_addr(addr), .o_dq_out(dq_out), .o_dq_oe(dq_oe), .o_wp_n(wp_pin), .i_dq_in(dq), .i_ready_busy_n(rdy_n));
  pfc_flash_model flash (.i_clk, .i_strobe(strobe), .i_addr(addr), .i_wp_n(wp_pin), .o_dq(dq), .o_ready_busy_n(rdy_n));
  initial begin
    forever #4 i_clk = ~i_clk;
  end
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp16
  task automatic cmp1(input logic got, input logic exp);
    cmp16({15'h0000, got}, {15'h0000, exp});
  endtask : cmp1
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  // Issue one request and collect its answer until idle again
  task automatic run(input pfc_row_t r);
    @(posedge i_clk);
    req       <= '{r.op, r.addr, 16'h1234};
    mode      <= r.mode;
    req_valid <= 1'b1;
    got_retry = 1'b0;
    got_rd    = NO_RD;
    got_wd    = NO_RD;
    do @(negedge i_clk); while (req_ready !== 1'b1);
    @(posedge i_clk);
    req_valid <= 1'b0;
    repeat (2) @(negedge i_clk);
    for (int n = 0; n < 4000 && req_ready !== 1'b1; n++) begin
      @(negedge i_clk);
      if (rd_valid === 1'b1) got_rd = rd_data;
      if (retry === 1'b1) got_retry = 1'b1;
      if (dq_oe === 1'b1) got_wd = dq_out;
    end
    cmp1(req_ready, 1'b1);
  endtask : run
  initial begin
    #400000;
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    foreach (rows[i]) begin
      run(rows[i]);
      cmp16(got_rd, rows[i].rd);
      cmp1(got_retry, rows[i].retry);
      if (rows[i].op == pfc_pkg::PFC_OP_WRITE) begin
        cmp16(got_wd, 16'h1234);
      end
    end
    // Reset in the middle of a read
    @(posedge i_clk);
    req       <= '{pfc_pkg::PFC_OP_READ, 22'h000100, 16'h0000};
    req_valid <= 1'b1;
    repeat (5) @(posedge i_clk);
    req_valid <= 1'b0;
    i_reset   <= 1'b1;
    @(posedge i_clk);
    i_reset   <= 1'b0;
    @(negedge i_clk);
    cmp16({8'h00, dq_oe, strobe}, 16'h0078);
    run('{pfc_pkg::PFC_OP_READ, 2'h1, 22'h000100, 16'hC2A5, 1'h0});
    cmp16(got_rd, 16'hC2A5);
    print_verdict();
  end
endmodule : tb_pfc_host
bind pfc_host pfc_host_sva u_sva (.i_clk, .i_reset, .i_wp_n, .o_rd_valid, .o_dq_oe, .o_wp_n, .o_strobe);
